//--- perf_counter_group_params.svh
// Purpose: Offsets, field positions, event numbers and reset values of the counter group
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef PERF_COUNTER_GROUP_PARAMS_SVH
`define PERF_COUNTER_GROUP_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_CFG       12'h000
`define OFS_CTRL      12'h004
`define OFS_CAPTURE   12'h008
`define OFS_OVF_STAT_LO 12'h010
`define OFS_OVF_STAT_HI 12'h014
`define OFS_EVT_LO    12'h018
`define OFS_EVT_HI    12'h01c
`define OFS_CNT_BASE  12'h400
`define OFS_SHD_BASE  12'h600
`define OFS_SEL_BASE  12'h800
`define OFS_FLT_BASE  12'ha00

// ==========================================================================
// Field positions
`define CTRL_IRQ_EN_BIT   0
`define CTRL_MSI_EN_BIT   1
`define CTRL_CNT_EN_BIT   2
`define CAP_TRIG_BIT      0
`define CFG_CAP_BIT       16
`define CFG_NCNT_LSB      0
`define SEL_EVENT_LSB     0
`define SEL_SPAN_BIT      16
`define SEL_FLT_EN_BIT    17
`define SEL_OVF_IRQ_BIT   18
`define SEL_OVF_CAP_BIT   19

// ==========================================================================
// Event numbering and reset values
`define EVT_ARCH_MAX      16'h007f
`define EVT_CLOCK         16'h0000
`define EVT_TRANSACTION   16'h0001
`define CTRL_RESET        32'h0000_0004

`endif

//--- perf_counter_group_pkg.sv
// Purpose: Types shared by the counter group files
// Assumes: Nothing
// Notes:   Types only; numbers live in the params header
package perf_counter_group_pkg;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_DONE = 2'b11
  } rd_state_t;
endpackage : perf_counter_group_pkg

//--- shadow_if.sv
// Purpose: Carries capture and read ports of the shadow memory
// Assumes: One clock
// Notes:   Read data is registered in the memory
`timescale 1ns/100ps
`default_nettype none
interface shadow_if #(parameter int NUM_CNT = 4, parameter int CNT_W = 32, parameter int IDX_W = 2);
  logic                   capture;
  logic [NUM_CNT*CNT_W-1:0] snap;
  logic [IDX_W-1:0]       rd_idx;
  logic [CNT_W-1:0]       rd_data;
  modport owner  (output capture, output snap, output rd_idx, input rd_data);
  modport memory (input capture, input snap, input rd_idx, output rd_data);
endinterface : shadow_if
`default_nettype wire

//--- shadow_mem.sv
// Purpose: Shadow copies of all counters, loaded together on capture
// Assumes: Capture is a one-cycle pulse
// Notes:   Read data comes out of a register one cycle after the index
`timescale 1ns/100ps
`default_nettype none
module shadow_mem
  import perf_counter_group_pkg::*;
#(
  parameter int NUM_CNT = 4,
  parameter int CNT_W   = 32
)(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Shadow port
  shadow_if.memory  sh
);
  logic [CNT_W-1:0] mem_q [NUM_CNT];
  logic [CNT_W-1:0] rd_q;

  // ==========================================================================
  // Simultaneous copy of every counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_CNT; i++)
        mem_q[i] <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (sh.capture)
        for (int i = 0; i < NUM_CNT; i++)
          mem_q[i] <= sh.snap[i*CNT_W +: CNT_W];
      rd_q <= mem_q[sh.rd_idx];
    end
  end
  assign sh.rd_data = rd_q;
endmodule : shadow_mem
`default_nettype wire

//--- perf_counter_group.sv
// Purpose: Performance monitor counter group with APB registers
// Assumes: Events arrive as one-cycle pulses synchronous to pclk with their stream identifier
// Notes:   Wired interrupt is a one-cycle pulse; message interrupt is a request pulse
`timescale 1ns/100ps
`default_nettype none
`include "perf_counter_group_params.svh"
module perf_counter_group
  import perf_counter_group_pkg::*;
#(
  parameter int          NUM_CNT  = 4,
  parameter int          CNT_W    = 32,
  parameter int          NUM_EVT  = 8,
  parameter int          SID_W    = 16,
  // Default stream range covers every stream, as suits group zero
  parameter logic [SID_W-1:0] SID_BASE = '0,
  parameter logic [SID_W-1:0] SID_LAST = '1,
  parameter logic        HAS_CAP  = 1'b1,
  parameter logic [63:0] EVT_SUPPORTED = 64'h0000_0000_0000_00ff
)(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Event sources
  input  wire logic [NUM_EVT-1:0]  event_pulse,
  input  wire logic [SID_W-1:0]    event_sid,
  input  wire logic                event_terminated,
  input  wire logic                translation_enable,
  input  wire logic                ext_capture,
  // Interrupts
  output logic                     irq_wired,
  output logic                     msi_req,
  output logic                     msi_coherent
);
  // Counter index width, at least one bit
  localparam int IDX_W = (NUM_CNT > 1) ? $clog2(NUM_CNT) : 1;

  // ==========================================================================
  // Stream filter: exact, or the trailing ones and the first zero above them are ignored
  function automatic logic sid_match(input logic [SID_W-1:0] flt, input logic span,
                                     input logic [SID_W-1:0] sid);
    logic [SID_W-1:0] care;
    logic             seen0;
    care  = '1;
    seen0 = 1'b0;
    if (span)
      for (int b = 0; b < SID_W; b++)
      begin
        if (!seen0)
          care[b] = 1'b0;
        if (!flt[b])
          seen0 = 1'b1;
      end
    // All ones with span set matches every stream
    if (span && &flt)
      care = '0;
    return ((flt ^ sid) & care) == '0;
  endfunction : sid_match

  // ==========================================================================
  // Event selection: unsupported or unimplemented identifiers never count
  function automatic logic event_seen(input logic [15:0] ev, input logic [NUM_EVT-1:0] pulses);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < NUM_EVT && n < 64; n++)
      if (ev == 16'(n) && EVT_SUPPORTED[n] && pulses[n])
        seen = 1'b1;
    return seen;
  endfunction : event_seen

  // Write access landing on counter i of a per-counter bank
  function automatic logic bank_wr(input logic acc, input logic in_bank, input logic [IDX_W-1:0] at, input int i);
    return acc && in_bank && at == IDX_W'(i);
  endfunction : bank_wr

  // ==========================================================================
  // Registers
  logic [31:0]        ctrl_q;
  logic [NUM_CNT-1:0] ovf_stat_q;
  logic [CNT_W-1:0]   cnt_q  [NUM_CNT];
  logic [31:0]        sel_q  [NUM_CNT];
  logic [SID_W-1:0]   flt_q  [NUM_CNT];
  logic [31:0]        rdata_q;
  rd_state_t          rd_state_q;
  logic               irq_q;
  logic               msi_q;

  // Capture and read port of the shadow memory
  shadow_if #(.NUM_CNT(NUM_CNT), .CNT_W(CNT_W), .IDX_W(IDX_W)) sh ();

  // ==========================================================================
  // APB decode
  wire        setup_rd  = psel && !penable && !pwrite;
  wire        wr_acc    = psel && penable && pwrite;
  wire        rd_acc    = psel && penable && !pwrite;
  // Per-counter banks are 512 bytes apart; the index must name an existing counter
  wire [11:0] base_addr = {paddr[11:9], 9'h000};
  wire [6:0]  word_idx  = paddr[8:2];
  wire        idx_ok    = 32'(word_idx) < NUM_CNT;
  wire [IDX_W-1:0] idx  = IDX_W'(word_idx);
  wire        is_cnt    = base_addr == `OFS_CNT_BASE && idx_ok;
  wire        is_shd    = base_addr == `OFS_SHD_BASE && idx_ok && HAS_CAP;
  wire        is_sel    = base_addr == `OFS_SEL_BASE && idx_ok;
  wire        is_flt    = base_addr == `OFS_FLT_BASE && idx_ok;
  wire        is_cfg    = paddr == `OFS_CFG;
  wire        is_ctrl   = paddr == `OFS_CTRL;
  wire        is_cap    = paddr == `OFS_CAPTURE;
  wire        is_stat_lo = paddr == `OFS_OVF_STAT_LO;
  wire        is_stat_hi = paddr == `OFS_OVF_STAT_HI;
  wire        is_evt_lo = paddr == `OFS_EVT_LO;
  wire        is_evt_hi = paddr == `OFS_EVT_HI;
  wire        is_misc   = is_cfg || is_ctrl || is_cap || is_stat_lo || is_stat_hi || is_evt_lo || is_evt_hi;
  wire        mapped    = is_cnt || is_shd || is_sel || is_flt || is_misc;
  wire        shd_rd    = rd_acc && is_shd;

  // Shadow reads take two extra cycles through the memory's output register
  assign pready  = !(shd_rd && rd_state_q != RD_DONE);
  assign pslverr = psel && penable && !mapped;
  assign prdata  = (rd_state_q == RD_DONE) ? sh.rd_data : rdata_q;
  assign sh.rd_idx = idx;

  wire [63:0] ovf_stat_wide = 64'(ovf_stat_q);
  wire        cap_sw        = wr_acc && is_cap && pwdata[`CAP_TRIG_BIT] && HAS_CAP;
  wire        stat_clr_lo   = wr_acc && is_stat_lo;
  wire        stat_clr_hi   = wr_acc && is_stat_hi;
  wire [63:0] stat_clr      = {stat_clr_hi ? pwdata : 32'h0, stat_clr_lo ? pwdata : 32'h0};

  // ==========================================================================
  // Counting
  logic [NUM_CNT-1:0] hit;
  logic [NUM_CNT-1:0] ovf;
  logic [NUM_CNT-1:0] ovf_cap;
  logic [NUM_CNT-1:0] ovf_irq;
  logic [CNT_W-1:0]   cnt_d [NUM_CNT];
  // Streams outside the group's fixed range never pass a filter
  wire  sid_in_group = event_sid >= SID_BASE && event_sid <= SID_LAST;
  // Counting stops when software disables it or translation is off
  wire  count_on     = ctrl_q[`CTRL_CNT_EN_BIT] && translation_enable;

  always_comb
  begin
    for (int i = 0; i < NUM_CNT; i++)
    begin
      logic [15:0] ev;
      logic        raw;
      logic        filt_ok;
      ev      = sel_q[i][`SEL_EVENT_LSB +: 16];
      raw     = event_seen(ev, event_pulse);
      // Terminated transactions never count as passed through
      if (ev == `EVT_TRANSACTION && event_terminated)
        raw = 1'b0;
      filt_ok = (ev == `EVT_CLOCK) || !sel_q[i][`SEL_FLT_EN_BIT] ||
                (sid_in_group && sid_match(flt_q[i], sel_q[i][`SEL_SPAN_BIT], event_sid));
      hit[i]  = count_on && raw && filt_ok;
      {ovf[i], cnt_d[i]} = {1'b0, cnt_q[i]} + (CNT_W+1)'(hit[i]);
      ovf_cap[i] = ovf[i] && sel_q[i][`SEL_OVF_CAP_BIT];
      ovf_irq[i] = ovf[i] && sel_q[i][`SEL_OVF_IRQ_BIT];
    end
  end

  // Snapshot post-increment values so an overflow capture sees the wrap
  always_comb
  begin
    for (int i = 0; i < NUM_CNT; i++)
      sh.snap[i*CNT_W +: CNT_W] = cnt_d[i];
  end
  assign sh.capture = HAS_CAP && (cap_sw || ext_capture || |ovf_cap);

  wire irq_event = ctrl_q[`CTRL_IRQ_EN_BIT] && |ovf_irq;

  // ==========================================================================
  // Register writes and counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `CTRL_RESET;
      ovf_stat_q <= '0;
      for (int i = 0; i < NUM_CNT; i++)
      begin
        cnt_q[i] <= '0;
        sel_q[i] <= '0;
        flt_q[i] <= '0;
      end
    end
    else
    begin
      if (wr_acc && is_ctrl)
        ctrl_q <= pwdata;
      // Set wins over clear in the same cycle
      ovf_stat_q <= (ovf_stat_q & ~stat_clr[NUM_CNT-1:0]) | ovf;
      for (int i = 0; i < NUM_CNT; i++)
      begin
        // A counter write wins over an increment in the same cycle
        if (bank_wr(wr_acc, is_cnt, idx, i))
          cnt_q[i] <= pwdata[CNT_W-1:0];
        else
          cnt_q[i] <= cnt_d[i];
        if (bank_wr(wr_acc, is_sel, idx, i))
          sel_q[i] <= pwdata;
        if (bank_wr(wr_acc, is_flt, idx, i))
          flt_q[i] <= pwdata[SID_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Read path and interrupt pulses
  // Configuration word: counters minus one and the capture capability
  wire [5:0]  cfg_ncnt = 6'(NUM_CNT - 1);
  wire        cfg_cap  = HAS_CAP;
  wire [31:0] cfg_word = (32'(cfg_ncnt) << `CFG_NCNT_LSB) | (32'(cfg_cap) << `CFG_CAP_BIT);
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (is_cnt)
      rd_mux = 32'(cnt_q[idx]);
    else if (is_sel)
      rd_mux = sel_q[idx];
    else if (is_flt)
      rd_mux = 32'(flt_q[idx]);
    else if (is_cfg)
      rd_mux = cfg_word;
    else if (is_ctrl)
      rd_mux = ctrl_q;
    else if (is_stat_lo)
      rd_mux = ovf_stat_wide[31:0];
    else if (is_stat_hi)
      rd_mux = ovf_stat_wide[63:32];
    else if (is_evt_lo)
      rd_mux = EVT_SUPPORTED[31:0];
    else if (is_evt_hi)
      rd_mux = EVT_SUPPORTED[63:32];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q    <= 32'h0;
      rd_state_q <= RD_IDLE;
      irq_q      <= 1'b0;
      msi_q      <= 1'b0;
    end
    else
    begin
      // Read data is taken in the setup cycle and held until the next read
      if (setup_rd)
        rdata_q <= rd_mux;
      case (rd_state_q)
        RD_IDLE: rd_state_q <= shd_rd ? RD_WAIT : RD_IDLE;
        RD_WAIT: rd_state_q <= RD_DONE;
        RD_DONE: rd_state_q <= RD_IDLE;
        default: rd_state_q <= RD_IDLE;
      endcase
      // Registered one-cycle pulses give a clean edge
      irq_q <= irq_event;
      msi_q <= irq_event && ctrl_q[`CTRL_MSI_EN_BIT];
    end
  end

  assign irq_wired    = irq_q;
  assign msi_req      = msi_q;
  // Message writes never claim coherence
  assign msi_coherent = 1'b0;

  shadow_mem #(.NUM_CNT(NUM_CNT), .CNT_W(CNT_W)) u_shadow (
    .pclk    (pclk),
    .presetn (presetn),
    .sh      (sh)
  );
endmodule : perf_counter_group
`default_nettype wire

//--- perf_counter_group_properties.sv
// Purpose: Port-level checks of the performance counter group
// Assumes: Bound to perf_counter_group, one clock domain
// Notes:   Waits and interrupt timing follow the design's bus and event timing
`timescale 1ns/100ps
`default_nettype none
module perf_counter_group_properties #(
  parameter int NUM_EVT = 8
)(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Register bus
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  // Events and interrupts
  input wire logic [NUM_EVT-1:0] event_pulse,
  input wire logic               translation_enable,
  input wire logic               irq_wired,
  input wire logic               msi_req,
  input wire logic               msi_coherent
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ========================================
  // Assertions
  property p_no_coherent; msi_coherent == 1'b0; endproperty
  a_no_coherent: assert property (p_no_coherent)
    else $error("message write claims coherence");
  property p_msi_with_wire; msi_req |-> irq_wired; endproperty
  a_msi_with_wire: assert property (p_msi_with_wire)
    else $error("message request without wired pulse");
  property p_irq_cause; irq_wired |-> $past(translation_enable, 1) && $past(|event_pulse, 1); endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without a counted event");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error outside access phase");
  property p_err_rdata; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_rdata: assert property (p_err_rdata)
    else $error("refused read returns data");
  property p_idle_ready; !(psel && penable) |-> pready; endproperty
  a_idle_ready: assert property (p_idle_ready)
    else $error("ready low outside access phase");
  property p_wait_bound; psel && penable && !pready |-> ##[1:2] pready; endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("shadow read wait too long");
  property p_wait_read; psel && penable && !pready |-> !pwrite && !pslverr; endproperty
  a_wait_read: assert property (p_wait_read)
    else $error("wait state on a write");

  // ========================================
  // Coverage
  c_irq: cover property (irq_wired && msi_req);
  c_err: cover property (pslverr);
  c_wait: cover property (psel && penable && !pready);
endmodule : perf_counter_group_properties
`default_nettype wire

//--- perf_counter_group_tb.sv
// Purpose: Self-checking bench for the performance counter group
// Assumes: Default design parameters, four counters, eight events
// Notes:   Bus driven by non-blocking assignment after rising edges
`timescale 1ns/100ps
`default_nettype none
`include "perf_counter_group_params.svh"
module perf_counter_group_tb import perf_counter_group_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  event_pulse;
  logic [15:0] event_sid;
  logic        event_terminated, translation_enable, ext_capture, irq_wired, msi_req, msi_coherent;
  int          errors, n_compared, cycles, irqs, msis;

  perf_counter_group u_perf_counter_group (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .event_pulse(event_pulse), .event_sid(event_sid), .event_terminated(event_terminated),
    .translation_enable(translation_enable), .ext_capture(ext_capture), .irq_wired(irq_wired),
    .msi_req(msi_req), .msi_coherent(msi_coherent));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ========================================
  // Interrupt counting and hang limit
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (irq_wired === 1'b1) irqs <= irqs + 1;
    if (msi_req === 1'b1) msis <= msis + 1;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  // ========================================
  // Bus, event and compare tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic ev(input logic [7:0] p, input logic [15:0] s, input logic t);
    @(posedge pclk);
    event_pulse <= p;
    event_sid <= s;
    event_terminated <= t;
    @(posedge pclk);
    event_pulse <= 8'h00;
    event_terminated <= 1'b0;
  endtask : ev

  task automatic complete_run();
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // ========================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, presetn, event_terminated, ext_capture} = '0;
    {paddr, pwdata, event_pulse, event_sid} = '0;
    translation_enable = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`OFS_CTRL, `CTRL_RESET);
    rdchk(`OFS_CFG, 32'h0001_0003);
    rdchk(`OFS_EVT_LO, 32'h0000_00ff);
    rdchk(`OFS_OVF_STAT_LO, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    for (int e = 0; e < 8; e++)
    begin
      apb(1'b1, `OFS_SEL_BASE, 32'(e));
      apb(1'b1, `OFS_CNT_BASE, 32'h0);
      ev(~(8'h01 << e), 16'h0005, 1'b0);
      ev(8'h01 << e, 16'h0005, 1'b0);
      ev(8'h01 << e, 16'h0005, 1'b0);
      rdchk(`OFS_CNT_BASE, 32'h2);
    end
    apb(1'b1, `OFS_CNT_BASE + 12'h004, 32'h0);
    apb(1'b1, `OFS_SEL_BASE + 12'h004, 32'h0002_0002);
    apb(1'b1, `OFS_FLT_BASE + 12'h004, 32'h0000_0012);
    ev(8'h04, 16'h0012, 1'b0);
    ev(8'h04, 16'h0013, 1'b0);
    rdchk(`OFS_CNT_BASE + 12'h004, 32'h1);
    apb(1'b1, `OFS_SEL_BASE + 12'h004, 32'h0003_0002);
    apb(1'b1, `OFS_FLT_BASE + 12'h004, 32'h0000_0011);
    ev(8'h04, 16'h0013, 1'b0);
    ev(8'h04, 16'h0014, 1'b0);
    rdchk(`OFS_CNT_BASE + 12'h004, 32'h2);
    apb(1'b1, `OFS_SEL_BASE + 12'h004, 32'h0000_0002);
    ev(8'h04, 16'h0099, 1'b0);
    rdchk(`OFS_CNT_BASE + 12'h004, 32'h3);
    apb(1'b1, `OFS_SEL_BASE + 12'h004, 32'h0002_0000);
    ev(8'h01, 16'h0099, 1'b0);
    rdchk(`OFS_CNT_BASE + 12'h004, 32'h4);
    apb(1'b1, `OFS_SEL_BASE + 12'h004, 32'h0000_0001);
    ev(8'h02, 16'h0000, 1'b1);
    translation_enable <= 1'b0;
    ev(8'h02, 16'h0000, 1'b0);
    translation_enable <= 1'b1;
    rdchk(`OFS_CNT_BASE + 12'h004, 32'h4);
    apb(1'b1, `OFS_SEL_BASE + 12'h004, 32'h0000_0080);
    ev(8'hff, 16'h0000, 1'b0);
    rdchk(`OFS_CNT_BASE + 12'h004, 32'h4);
    // Overflow with interrupt and capture, counter 2 snapshotted too
    apb(1'b1, `OFS_CTRL, 32'h7);
    apb(1'b1, `OFS_SEL_BASE, 32'h000c_0003);
    apb(1'b1, `OFS_CNT_BASE, 32'hffff_ffff);
    apb(1'b1, `OFS_CNT_BASE + 12'h008, 32'h0000_0055);
    ev(8'h08, 16'h0000, 1'b0);
    rdchk(`OFS_OVF_STAT_LO, 32'h1);
    rdchk(`OFS_OVF_STAT_LO, 32'h1);
    rdchk(`OFS_SHD_BASE, 32'h0);
    rdchk(`OFS_SHD_BASE + 12'h008, 32'h0000_0055);
    chk(32'(irqs), 32'h1);
    chk(32'(msis), 32'h1);
    apb(1'b1, `OFS_OVF_STAT_LO, 32'h1);
    rdchk(`OFS_OVF_STAT_LO, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h6);
    apb(1'b1, `OFS_CNT_BASE, 32'hffff_ffff);
    ev(8'h08, 16'h0000, 1'b0);
    apb(1'b1, `OFS_CTRL, 32'h7);
    apb(1'b1, `OFS_SEL_BASE, 32'h0000_0003);
    apb(1'b1, `OFS_CNT_BASE, 32'hffff_ffff);
    ev(8'h08, 16'h0000, 1'b0);
    chk(32'(irqs), 32'h1);
    apb(1'b1, `OFS_CNT_BASE + 12'h008, 32'h0000_0077);
    apb(1'b1, `OFS_CAPTURE, 32'h1);
    rdchk(`OFS_SHD_BASE + 12'h008, 32'h0000_0077);
    apb(1'b1, `OFS_CNT_BASE + 12'h008, 32'h0000_0099);
    @(posedge pclk);
    ext_capture <= 1'b1;
    @(posedge pclk);
    ext_capture <= 1'b0;
    rdchk(`OFS_SHD_BASE + 12'h008, 32'h0000_0099);
    complete_run();
  end
endmodule : perf_counter_group_tb

bind perf_counter_group perf_counter_group_properties #(.NUM_EVT(NUM_EVT)) u_perf_counter_group_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .event_pulse(event_pulse), .translation_enable(translation_enable),
  .irq_wired(irq_wired), .msi_req(msi_req), .msi_coherent(msi_coherent));
`default_nettype wire
